/* core/idu_pkg.sv */
package idu_pkg;

    // Datapath width and fixed calculation length
    localparam int IDU_W              = 32;
    localparam int IDU_CYCLES         = 8;
    localparam int IDU_BITS_PER_CYCLE = IDU_W / IDU_CYCLES;

    // Counter layout for the iteration stepper
    localparam int IDU_CNT_W = $clog2(IDU_CYCLES);
    localparam logic [IDU_CNT_W-1:0] IDU_CNT_FIRST = 3'h0;
    localparam logic [IDU_CNT_W-1:0] IDU_CNT_LAST  = 3'h7;

    // Reset values of the visible state
    localparam logic [IDU_W-1:0] IDU_RST_WORD  = 32'h00000000;
    localparam logic             IDU_RST_READY = 1'h1;
    localparam logic             IDU_RST_DIRTY = 1'h0;

    // Quotient pattern produced when the divisor is zero
    localparam logic [IDU_W-1:0] IDU_DIV0_QUOTIENT = 32'hFFFFFFFF;

    // Which divider location a port write targets
    typedef enum logic [2:0] {
        IDU_TGT_NONE,
        IDU_TGT_SIGNED_DIVIDEND,
        IDU_TGT_SIGNED_DIVISOR,
        IDU_TGT_UNSIGNED_DIVIDEND,
        IDU_TGT_UNSIGNED_DIVISOR,
        IDU_TGT_QUOTIENT,
        IDU_TGT_REMAINDER
    } idu_target_e;

    // One single-cycle write from the core's I/O port
    typedef struct packed {
        idu_target_e      target;
        logic [IDU_W-1:0] data;
    } idu_wr_s;

endpackage

/* core/idu_step.sv */
// Combinational restoring-division slice: several quotient bits per call
module idu_step
    import idu_pkg::*;
#(
    parameter int W = IDU_W,
    parameter int S = IDU_BITS_PER_CYCLE
) (
    input  wire logic [W-1:0] rem_in,   // Partial remainder so far
    input  wire logic [W-1:0] quo_in,   // Dividend bits still to shift in, quotient bits out
    input  wire logic [W-1:0] div_in,   // Divisor magnitude
    output logic      [W-1:0] rem_out,  // Partial remainder after S bits
    output logic      [W-1:0] quo_out   // Shift register after S bits
);

    // Unrolled by the loop; S subtract stages sit in one clock period
    always_comb begin
        logic [W:0]   trial;
        logic [W-1:0] r;
        logic [W-1:0] q;
        trial = '0;
        r     = rem_in;
        q     = quo_in;
        for (int i = 0; i < S; i++) begin
            trial = {r, q[W-1]};
            q     = {q[W-2:0], 1'h0};
            // Subtract only when it fits, so the remainder never goes negative
            if (trial >= {1'h0, div_in}) begin
                trial = trial - {1'h0, div_in};
                q[0]  = 1'h1;
            end
            r = trial[W-1:0];
        end
        rem_out = r;
        quo_out = q;
    end

endmodule

/* core/idu_top.sv */
module idu_top
    import idu_pkg::*;
#(
    parameter int W = IDU_W
) (
    input  wire logic         clk,          // System clock, 40 MHz
    input  wire logic         nrst,         // Synchronous reset, active low
    input  wire idu_wr_s      wr,           // Port write: target and data, one cycle
    input  wire logic         rd_quotient,  // Port read of the quotient, one cycle
    output logic      [W-1:0] quotient,     // Quotient register
    output logic      [W-1:0] remainder,    // Remainder register
    output logic      [W-1:0] dividend,     // Stored dividend operand
    output logic      [W-1:0] divisor,      // Stored divisor operand
    output logic              ready,        // Control/status ready bit
    output logic              dirty         // Control/status dirty bit
);

    // Magnitude of a value, taken as two's complement only when signed
    function automatic logic [W-1:0] idu_mag(input logic [W-1:0] v, input logic sg);
        return (sg && v[W-1]) ? (~v + W'(1'h1)) : v;
    endfunction

    // Apply a sign to a magnitude
    function automatic logic [W-1:0] idu_apply(input logic [W-1:0] v, input logic neg);
        return neg ? (~v + W'(1'h1)) : v;
    endfunction

    // Visible registers
    logic [W-1:0]         quotient_reg;   // Result: quotient
    logic [W-1:0]         remainder_reg;  // Result: remainder
    logic [W-1:0]         dividend_reg;   // Operand: dividend, kept between runs
    logic [W-1:0]         divisor_reg;    // Operand: divisor, kept between runs
    logic                 ready_reg;      // Results valid
    logic                 dirty_reg;      // State touched since last quotient read

    // Calculation state
    logic                 busy_reg;       // Iteration under way
    logic [IDU_CNT_W-1:0] cnt_reg;        // Iteration index, 0 to 7
    logic [W-1:0]         rem_work_reg;   // Partial remainder magnitude
    logic [W-1:0]         quo_work_reg;   // Dividend in, quotient out
    logic [W-1:0]         dmag_reg;       // Divisor magnitude
    logic                 neg_q_reg;      // Quotient must be negated
    logic                 neg_r_reg;      // Remainder must be negated
    logic                 zero_reg;       // Divisor was zero
    logic                 signed_reg;     // Signedness of the running calculation

    // Write decode
    wire wr_s_dvd    = (wr.target == IDU_TGT_SIGNED_DIVIDEND);
    wire wr_s_dvs    = (wr.target == IDU_TGT_SIGNED_DIVISOR);
    wire wr_u_dvd    = (wr.target == IDU_TGT_UNSIGNED_DIVIDEND);
    wire wr_u_dvs    = (wr.target == IDU_TGT_UNSIGNED_DIVISOR);
    wire wr_quo      = (wr.target == IDU_TGT_QUOTIENT);
    wire wr_rem      = (wr.target == IDU_TGT_REMAINDER);
    wire wr_dvd      = wr_s_dvd | wr_u_dvd;
    wire wr_dvs      = wr_s_dvs | wr_u_dvs;
    wire start       = wr_dvd | wr_dvs;
    wire start_sg    = wr_s_dvd | wr_s_dvs;
    wire res_write   = wr_quo | wr_rem;
    wire any_write   = start | res_write;

    // Operands as they stand after this cycle's write
    wire [W-1:0] dvd_next = wr_dvd ? wr.data : dividend_reg;
    wire [W-1:0] dvs_next = wr_dvs ? wr.data : divisor_reg;

    // Iteration slice and final sign fix-up
    logic [W-1:0] step_rem;
    logic [W-1:0] step_quo;
    wire          last_step = busy_reg && (cnt_reg == IDU_CNT_LAST);
    wire [W-1:0]  quo_final = zero_reg ? IDU_DIV0_QUOTIENT : idu_apply(step_quo, neg_q_reg);
    wire [W-1:0]  rem_final = zero_reg ? dividend_reg : idu_apply(step_rem, neg_r_reg);

    idu_step #(
        .W (W),
        .S (IDU_BITS_PER_CYCLE)
    ) i_idu_step (
        .rem_in  (rem_work_reg),
        .quo_in  (quo_work_reg),
        .div_in  (dmag_reg),
        .rem_out (step_rem),
        .quo_out (step_quo)
    );

    // Operand storage; only operand writes change it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dividend_reg <= IDU_RST_WORD;
            divisor_reg  <= IDU_RST_WORD;
        end else begin
            dividend_reg <= dvd_next;
            divisor_reg  <= dvs_next;
        end
    end

    // Sequencer: a start reloads everything, so a restart squashes the old run
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_reg   <= 1'h0;
            cnt_reg    <= IDU_CNT_FIRST;
            signed_reg <= 1'h0;
        end else if (res_write) begin
            busy_reg   <= 1'h0;
            cnt_reg    <= IDU_CNT_FIRST;
        end else if (start) begin
            busy_reg   <= 1'h1;
            cnt_reg    <= IDU_CNT_FIRST;
            signed_reg <= start_sg;
        end else if (busy_reg) begin
            busy_reg   <= !last_step;
            cnt_reg    <= cnt_reg + IDU_CNT_W'(1);
        end
    end

    // Working registers: magnitudes and sign flags captured at the start
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rem_work_reg <= IDU_RST_WORD;
            quo_work_reg <= IDU_RST_WORD;
            dmag_reg     <= IDU_RST_WORD;
            neg_q_reg    <= 1'h0;
            neg_r_reg    <= 1'h0;
            zero_reg     <= 1'h0;
        end else if (start) begin
            rem_work_reg <= IDU_RST_WORD;
            quo_work_reg <= idu_mag(dvd_next, start_sg);
            dmag_reg     <= idu_mag(dvs_next, start_sg);
            neg_q_reg    <= start_sg && (dvd_next[W-1] ^ dvs_next[W-1]);
            neg_r_reg    <= start_sg && dvd_next[W-1];
            zero_reg     <= (dvs_next == IDU_RST_WORD);
        end else if (busy_reg) begin
            rem_work_reg <= step_rem;
            quo_work_reg <= step_quo;
        end
    end

    // Results: written by the core, or by the last iteration
    // Nothing here holds the port off; reads see the registers directly
    always_ff @(posedge clk) begin
        if (!nrst) begin
            quotient_reg  <= IDU_RST_WORD;
            remainder_reg <= IDU_RST_WORD;
        end else if (res_write) begin
            if (wr_quo) begin
                quotient_reg  <= wr.data;
            end
            if (wr_rem) begin
                remainder_reg <= wr.data;
            end
        end else if (last_step && !start) begin
            quotient_reg  <= quo_final;
            remainder_reg <= rem_final;
        end
    end

    // Ready: low from the cycle after a start until the last iteration lands
    // A blind wait of nine port cycles relies on this same fixed length
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ready_reg <= IDU_RST_READY;
        end else if (res_write) begin
            ready_reg <= 1'h1;
        end else if (start) begin
            ready_reg <= 1'h0;
        end else if (last_step) begin
            ready_reg <= 1'h1;
        end
    end

    // Dirty: a write in the same cycle as a quotient read wins, so no write is lost
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dirty_reg <= IDU_RST_DIRTY;
        end else if (any_write) begin
            dirty_reg <= 1'h1;
        end else if (rd_quotient) begin
            dirty_reg <= 1'h0;
        end
    end

    assign quotient  = quotient_reg;
    assign remainder = remainder_reg;
    assign dividend  = dividend_reg;
    assign divisor   = divisor_reg;
    assign ready     = ready_reg;
    assign dirty     = dirty_reg;

    // Helper for assertions: snapshot of the write data one cycle back
    logic [W-1:0] wr_data_q;
    always_ff @(posedge clk) begin
        wr_data_q <= wr.data;
    end

    // Results land at the eighth edge after the start, so ready is seen in the ninth cycle
    a_ready_after_eight: assert property (@(posedge clk) disable iff (!nrst)
        start ##1 (!any_write)[*8] |=> ready)
        else $error("ready not high nine cycles after start");

    a_ready_low_busy: assert property (@(posedge clk) disable iff (!nrst)
        start ##1 (!any_write)[*7] |-> !ready)
        else $error("ready high before calculation finished");

    a_ready_rise_origin: assert property (@(posedge clk) disable iff (!nrst)
        $rose(ready) && !$past(res_write) |-> $past(start, 9))
        else $error("ready rose without a start nine cycles earlier");

    a_restart_squash: assert property (@(posedge clk) disable iff (!nrst)
        start |=> busy_reg && (cnt_reg == IDU_CNT_FIRST) && !ready)
        else $error("operand write did not restart the calculation");

    a_sign_alias: assert property (@(posedge clk) disable iff (!nrst)
        start |=> signed_reg == $past(start_sg))
        else $error("signedness does not follow the written alias");

    a_operand_keep: assert property (@(posedge clk) disable iff (!nrst)
        !wr_dvs |=> $stable(divisor))
        else $error("divisor changed without a divisor write");

    a_result_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_quo |=> quotient == wr_data_q)
        else $error("written quotient not stored");

    a_result_cancel: assert property (@(posedge clk) disable iff (!nrst)
        wr_rem ##1 (!any_write)[*8] |-> remainder == $past(wr.data, 8) && ready)
        else $error("result write overwritten by cancelled calculation");

    a_dirty_set: assert property (@(posedge clk) disable iff (!nrst)
        any_write |=> dirty)
        else $error("dirty not set after a write");

    a_dirty_clear: assert property (@(posedge clk) disable iff (!nrst)
        rd_quotient && !any_write |=> !dirty)
        else $error("quotient read did not clear dirty");

    a_dirty_hold: assert property (@(posedge clk) disable iff (!nrst)
        !rd_quotient && !any_write |=> $stable(dirty))
        else $error("dirty changed with no write or quotient read");

    a_div_zero: assert property (@(posedge clk) disable iff (!nrst)
        (start && (dvs_next == IDU_RST_WORD)) ##1 (!any_write)[*8] |=> quotient == IDU_DIV0_QUOTIENT)
        else $error("divide by zero gave wrong quotient pattern");

    a_reset_state: assert property (@(posedge clk)
        !nrst |=> ready && !dirty && quotient == IDU_RST_WORD && dividend == IDU_RST_WORD)
        else $error("reset did not clear divider state");

    // The remainder of a zero divisor is the raw dividend that started the run
    a_zero_remainder: assert property (@(posedge clk) disable iff (!nrst)
        (start && (dvs_next == IDU_RST_WORD)) ##1 (!any_write)[*8] |=> remainder == $past(dvd_next, 9))
        else $error("divide by zero gave wrong remainder");

    // Ready is simply the inverse of the busy flag; a mismatch means a lost transition
    a_ready_busy_match: assert property (@(posedge clk) disable iff (!nrst)
        ready != busy_reg)
        else $error("ready and busy disagree");

    a_count_advance: assert property (@(posedge clk) disable iff (!nrst)
        busy_reg && !last_step && !any_write |=> busy_reg && !$stable(cnt_reg))
        else $error("iteration counter stalled");

    a_busy_done: assert property (@(posedge clk) disable iff (!nrst)
        last_step && !any_write |=> !busy_reg && ready)
        else $error("calculation did not finish after its last step");

    // Results move only by a core write or by a finishing run, never by a read
    a_result_hold: assert property (@(posedge clk) disable iff (!nrst)
        !res_write && !last_step |=> $stable(quotient) && $stable(remainder))
        else $error("results changed with no write or completion");

    a_dividend_store: assert property (@(posedge clk) disable iff (!nrst)
        wr_dvd |=> dividend == wr_data_q)
        else $error("written dividend not stored");

    a_divisor_store: assert property (@(posedge clk) disable iff (!nrst)
        wr_dvs |=> divisor == wr_data_q)
        else $error("written divisor not stored");

    a_dividend_keep: assert property (@(posedge clk) disable iff (!nrst)
        !wr_dvd |=> $stable(dividend))
        else $error("dividend changed without a dividend write");

    a_remainder_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_rem |=> remainder == wr_data_q)
        else $error("written remainder not stored");

    a_cancel_idle: assert property (@(posedge clk) disable iff (!nrst)
        res_write |=> !busy_reg && ready)
        else $error("result write did not cancel the calculation");

endmodule

/* testbench/idu_core_model.sv */
// Core side of the single-cycle I/O port
module idu_core_model
    import idu_pkg::*;
(
    input  wire logic clk,          // System clock
    output idu_wr_s   wr,           // Write toward the divider
    output logic      rd_quotient   // Quotient read strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Port idles from time zero so the divider never sees unknowns
    initial begin
        wr          = '{IDU_TGT_NONE, 32'h00000000};
        rd_quotient = 1'h0;
    end

    // Launched at a rising edge, sampled at the next one
    task automatic put(input idu_target_e t, input logic [31:0] d, input logic rd);
        @(posedge clk);
        wr          <= '{t, d};
        rd_quotient <= rd;
    endtask

    // Release the port for one cycle
    task automatic tick();
        @(posedge clk);
        wr          <= '{IDU_TGT_NONE, 32'h00000000};
        rd_quotient <= 1'h0;
    endtask

    // Blind wait instead of polling, cheaper than a status read loop
    task automatic wait_fixed();
        repeat (9) tick();
    endtask

    // Quotient is read last so saved state stays consistent
    task automatic read_quotient();
        put(IDU_TGT_NONE, 32'h00000000, 1'h1);
        tick();
    endtask
endmodule

/* testbench/integer_divide_unit_test.sv */
// Self-checking bench for the divide unit
module integer_divide_unit_test
    import idu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;          // 40 MHz system clock
    logic        nrst;         // Synchronous reset, active low
    idu_wr_s     wr;           // Write from the core model
    logic        rd_quotient;  // Quotient read strobe
    logic [31:0] quotient;     // Quotient register
    logic [31:0] remainder;    // Remainder register
    logic [31:0] dividend;     // Stored dividend
    logic [31:0] divisor;      // Stored divisor
    logic        ready;        // Ready bit
    logic        dirty;        // Dirty bit
    int          error_cnt;    // Mismatches
    int          n_compared;   // Comparisons made

    idu_top i_idu_top (.clk(clk), .nrst(nrst), .wr(wr), .rd_quotient(rd_quotient), .quotient(quotient),
        .remainder(remainder), .dividend(dividend), .divisor(divisor), .ready(ready), .dirty(dirty));
    idu_core_model i_idu_core_model (.clk(clk), .wr(wr), .rd_quotient(rd_quotient));

    // Half period of 12.5 ns
    always #12.5 clk = ~clk;

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Last operand write, then timing and results; a late ready check catches a missed restart
    task automatic calc(input idu_target_e t, input logic [31:0] d, input logic [31:0] q, input logic [31:0] r);
        i_idu_core_model.put(t, d, 1'h0);
        i_idu_core_model.tick();
        i_idu_core_model.tick();
        @(negedge clk);
        check("ready busy", 32'(ready), 32'h00000000);
        check("dirty", 32'(dirty), 32'h00000001);
        repeat (6) i_idu_core_model.tick();
        @(negedge clk);
        check("ready last", 32'(ready), 32'h00000000);
        i_idu_core_model.tick();
        @(negedge clk);
        check("ready done", 32'(ready), 32'h00000001);
        check("quotient", quotient, q);
        check("remainder", remainder, r);
    endtask

    // Dividend then divisor back to back
    task automatic run_div(input idu_target_e dt, input logic [31:0] dd, input idu_target_e vt,
                           input logic [31:0] vd, input logic [31:0] q, input logic [31:0] r);
        i_idu_core_model.put(dt, dd, 1'h0);
        calc(vt, vd, q, r);
        check("dividend", dividend, dd);
        check("divisor", divisor, vd);
    endtask

    // Values held in reset, checked before release
    task automatic t_reset();
        repeat (10) @(posedge clk);
        @(negedge clk);
        check("rst quotient", quotient, IDU_RST_WORD);
        check("rst remainder", remainder, IDU_RST_WORD);
        check("rst dividend", dividend, IDU_RST_WORD);
        check("rst divisor", divisor, IDU_RST_WORD);
        check("rst ready", 32'(ready), 32'(IDU_RST_READY));
        check("rst dirty", 32'(dirty), 32'(IDU_RST_DIRTY));
        @(posedge clk);
        nrst <= 1'h1;
        $display("Test reset done");
    endtask

    // Both aliases, sign corners and zero divisors
    task automatic t_signedness();
        run_div(IDU_TGT_SIGNED_DIVIDEND, 32'h00000007, IDU_TGT_SIGNED_DIVISOR, 32'hFFFFFFFE, 32'hFFFFFFFD, 32'h00000001);
        run_div(IDU_TGT_UNSIGNED_DIVIDEND, 32'h00000007, IDU_TGT_UNSIGNED_DIVISOR, 32'hFFFFFFFE, 32'h00000000,
                32'h00000007);
        run_div(IDU_TGT_SIGNED_DIVIDEND, 32'hFFFFFFF9, IDU_TGT_SIGNED_DIVISOR, 32'h00000002, 32'hFFFFFFFD, 32'hFFFFFFFF);
        run_div(IDU_TGT_UNSIGNED_DIVIDEND, 32'hFFFFFFF9, IDU_TGT_SIGNED_DIVISOR, 32'h00000002, 32'hFFFFFFFD,
                32'hFFFFFFFF);
        run_div(IDU_TGT_SIGNED_DIVIDEND, 32'h80000000, IDU_TGT_SIGNED_DIVISOR, 32'hFFFFFFFF, 32'h80000000, 32'h00000000);
        run_div(IDU_TGT_SIGNED_DIVIDEND, 32'hFFFFFF9C, IDU_TGT_SIGNED_DIVISOR, 32'h00000000, IDU_DIV0_QUOTIENT,
                32'hFFFFFF9C);
        run_div(IDU_TGT_UNSIGNED_DIVIDEND, 32'h00000005, IDU_TGT_UNSIGNED_DIVISOR, 32'h00000000, IDU_DIV0_QUOTIENT,
                32'h00000005);
        $display("Test signedness done");
    endtask

    // Divisor kept, signedness follows the dividend alias
    task automatic t_reuse();
        run_div(IDU_TGT_SIGNED_DIVIDEND, 32'h00000009, IDU_TGT_SIGNED_DIVISOR, 32'h00000002, 32'h00000004, 32'h00000001);
        calc(IDU_TGT_UNSIGNED_DIVIDEND, 32'hFFFFFFF9, 32'h7FFFFFFC, 32'h00000001);
        calc(IDU_TGT_SIGNED_DIVIDEND, 32'hFFFFFFF9, 32'hFFFFFFFD, 32'hFFFFFFFF);
        check("kept divisor", divisor, 32'h00000002);
        $display("Test reuse done");
    endtask

    // Rewrite in mid-run restarts the count
    task automatic t_restart();
        i_idu_core_model.put(IDU_TGT_UNSIGNED_DIVIDEND, 32'h00000064, 1'h0);
        i_idu_core_model.put(IDU_TGT_UNSIGNED_DIVISOR, 32'h00000007, 1'h0);
        repeat (4) i_idu_core_model.tick();
        calc(IDU_TGT_UNSIGNED_DIVIDEND, 32'h00000032, 32'h00000007, 32'h00000001);
        $display("Test restart done");
    endtask

    // Restore of results cancels the running division
    task automatic t_result_write();
        i_idu_core_model.put(IDU_TGT_UNSIGNED_DIVIDEND, 32'h00000064, 1'h0);
        i_idu_core_model.put(IDU_TGT_UNSIGNED_DIVISOR, 32'h00000007, 1'h0);
        repeat (3) i_idu_core_model.tick();
        i_idu_core_model.put(IDU_TGT_QUOTIENT, 32'h12345678, 1'h0);
        i_idu_core_model.put(IDU_TGT_REMAINDER, 32'hABCDEF01, 1'h0);
        repeat (10) i_idu_core_model.tick();
        @(negedge clk);
        check("restored quotient", quotient, 32'h12345678);
        check("restored remainder", remainder, 32'hABCDEF01);
        check("ready restored", 32'(ready), 32'h00000001);
        check("dirty restored", 32'(dirty), 32'h00000001);
        $display("Test result write done");
    endtask

    // Dirty clear by quotient read, set wins over a same-cycle read
    task automatic t_dirty();
        i_idu_core_model.read_quotient();
        @(negedge clk);
        check("dirty cleared", 32'(dirty), 32'h00000000);
        i_idu_core_model.put(IDU_TGT_REMAINDER, 32'h00000005, 1'h1);
        i_idu_core_model.tick();
        @(negedge clk);
        check("dirty set wins", 32'(dirty), 32'h00000001);
        i_idu_core_model.put(IDU_TGT_UNSIGNED_DIVIDEND, 32'h00000064, 1'h0);
        i_idu_core_model.put(IDU_TGT_UNSIGNED_DIVISOR, 32'h00000007, 1'h0);
        i_idu_core_model.wait_fixed();
        @(negedge clk);
        check("blind quotient", quotient, 32'h0000000E);
        check("blind remainder", remainder, 32'h00000002);
        i_idu_core_model.read_quotient();
        @(negedge clk);
        check("dirty after read", 32'(dirty), 32'h00000000);
        $display("Test dirty done");
    endtask

    // Main sequence
    initial begin
        clk        = 1'h0;
        nrst       = 1'h0;
        error_cnt  = 0;
        n_compared = 0;
        t_reset();
        t_signedness();
        t_reuse();
        t_restart();
        t_result_write();
        t_dirty();
        summarize();
    end

    // Watchdog: the tests need some 170 cycles, allow far more
    initial begin
        #(25 * 3000);
        error_cnt++;
        $display("Error watchdog expected finish seen timeout");
        summarize();
    end
endmodule
